// *** pulse_capture_pkg.sv ***
package pulse_capture_pkg;
  localparam int ADC_W            = 14;
  localparam int WAVE_DEPTH       = 8192;
  localparam int WAVE_AW          = 13;
  localparam int REC_DEPTH        = 500;
  localparam int REC_AW           = 9;
  localparam int TS_W             = 56;
  localparam int EDGE_TS_W        = 32;
  localparam int SUM_W            = 32;
  localparam int N_SUMS           = 3;
  localparam int COINC_W          = 4;
  localparam int TRIG_W           = 16;
  localparam int LEN_W            = 7;
  localparam int LINE_W           = 128;
  localparam int RANGE_W          = 3;
  localparam int DEC_W            = 6;
  localparam int ACC_W            = ADC_W + DEC_W;
  localparam int OOR_W            = 10;
  localparam int N_CNT            = 6;
  localparam int CNT_W            = 32;
  localparam int BUS_BYTES        = 4;
  localparam int BYTE_W           = 8;

  localparam logic [LEN_W-1:0]   FILT_LEN_MAX   = 7'd127;
  localparam logic [RANGE_W-1:0] SLOT_RANGE     = 3'd3;
  localparam logic [2:0]         OOR_HOLD_SHIFT = 3'd2;

  // Byte addresses of the Avalon word registers
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_THRESH   = 8'h04;
  localparam logic [7:0] ADDR_MAXW     = 8'h08;
  localparam logic [7:0] ADDR_PRETRIG  = 8'h0C;
  localparam logic [7:0] ADDR_TRACE    = 8'h10;
  localparam logic [7:0] ADDR_FILTER   = 8'h14;
  localparam logic [7:0] ADDR_STATUS   = 8'h18;
  localparam logic [7:0] ADDR_HDR      = 8'h1C;
  localparam logic [7:0] ADDR_CMD      = 8'h20;
  localparam logic [7:0] ADDR_REC_TSL  = 8'h24;
  localparam logic [7:0] ADDR_REC_TSH  = 8'h28;
  localparam logic [7:0] ADDR_REC_EDGE = 8'h2C;
  localparam logic [7:0] ADDR_REC_SUM0 = 8'h30;
  localparam logic [7:0] ADDR_REC_SUM1 = 8'h34;
  localparam logic [7:0] ADDR_REC_SUM2 = 8'h38;
  localparam logic [7:0] ADDR_REC_INFO = 8'h3C;
  localparam logic [7:0] ADDR_CNT_BASE = 8'h40;
  localparam logic [7:0] ADDR_CNT_LAST = 8'h54;

  localparam logic [31:0] MASK_CTRL   = 32'h0000_0003;
  localparam logic [31:0] MASK_16     = 32'h0000_FFFF;
  localparam logic [31:0] MASK_13     = 32'h0000_1FFF;
  localparam logic [31:0] MASK_FILTER = 32'h0007_3FFF;
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_PUR   = 1;
  localparam int FILT_RISE  = 0;
  localparam int FILT_FLAT  = 7;
  localparam int FILT_RANGE = 16;
  localparam logic [31:0] CMD_ACCEPT = 32'h0000_0001;
  localparam logic [31:0] CMD_REJECT = 32'h0000_0002;

  // Counter slots, read at ADDR_CNT_BASE + 4 * slot
  localparam int CNT_TOTAL = 0;
  localparam int CNT_RUN   = 1;
  localparam int CNT_COUNT = 2;
  localparam int CNT_SLOW_FILTER_DEAD_TIME  = 3;
  localparam int CNT_FAST_TRIGGER_DEAD_TIME = 4;
  localparam int CNT_GATE  = 5;

  typedef logic [N_SUMS-1:0][SUM_W-1:0] sums_t;

  typedef struct packed {
    logic [TS_W-1:0]      ts;
    logic [EDGE_TS_W-1:0] edge_ts;
    sums_t                sums;
    logic                 pileup;
    logic [COINC_W-1:0]   coinc;
    logic [WAVE_AW-1:0]   start_addr;
    logic [WAVE_AW-1:0]   trace_len;
  } rec_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } lm_beat_t;

  typedef struct packed {
    logic             gate;
    logic             oor;
    logic [ADC_W-1:0] adc;
  } pins_t;

  typedef enum {ST_IDLE, ST_HDR, ST_WAVE} out_state_t;
endpackage

// *** pulse_event_capture_deadtime.sv ***
// Notes on behaviour
// - One record per detected rising edge
// - Pre-trigger delayed samples fill waveform memory
// - Sum capture strobe delayed rise plus flat
// - Record latches stamps, sums, flags, address
// - 500 records, 8Ki waveform samples
// - Records-available flag while buffer not empty
// - Accepted: header then waveform from start
// - Rejected record removed, nothing streamed
// - Range 3 up: one record per slot
// - Three energy sums around the edge
// - Valid only if one pulse in window
// - Pileup latched at T1, both rejected
// - Slow filter dead time accumulated
// - One trigger per time over threshold
// - Over-width pulses marked as piled up
// - Full buffers pause acquisition, count time
// - Count time stops on range, backlog
// - Dead-time counters only while counting
// - Gate dead time own gated counter
// - Run and total time run while the run bit is set
// - Out of range dead plus filter purge
// - Decimated averaging, filter length capped 127
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
module pulse_event_capture_deadtime (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire pulse_capture_pkg::pins_t pin_in,
  input  wire logic [15:0]             trig_filter,
  input  wire pulse_capture_pkg::sums_t energy_sums,
  input  wire logic [3:0]              coinc_flags,
  input  wire logic                    lm_ready,
  input  wire logic                    lm_mem_full,
  input  wire logic [7:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  output logic                         records_available,
  output logic [13:0]                  decimated_sample,
  output pulse_capture_pkg::lm_beat_t  lm_out
);
  import pulse_capture_pkg::*;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  pins_t                pin_s1;
  pins_t                pin_s2;
  logic [31:0]          ctrl_reg, thr_reg, maxw_reg, pre_reg;
  logic [31:0]          trace_reg, filt_reg, hdr_reg;
  logic [TS_W-1:0]      timestamp;
  logic [DEC_W-1:0]     dec_cnt, dec_mask, slot_mask;
  logic [RANGE_W-1:0]   range;
  logic                 dec_en, slot_ok;
  logic [ACC_W-1:0]     avg_acc;
  logic [LEN_W:0]       len_sum;
  logic [LEN_W-1:0]     filt_len, busy_cnt;
  logic [LINE_W-1:0]    strobe_line;
  logic                 strobe, over, over_q, trig_rise, trig_pend, trig_dec;
  logic [TRIG_W-1:0]    over_cnt;
  logic                 tot_hit, pile;
  logic [EDGE_TS_W-1:0] last_edge_ts;
  logic [WAVE_AW-1:0]   last_addr, wr_ptr, rd_ptr, left;
  logic [OOR_W-1:0]     oor_cnt;
  logic                 oor_dead, run, run_q, run_start, pur_en;
  logic                 rec_full, wave_full, paused, acq_ok, count_on;
  logic [ADC_W-1:0]     wave_mem [WAVE_DEPTH];
  rec_t                 rec_mem [REC_DEPTH];
  rec_t                 cap_rec, head_rec;
  logic                 cap_pend, push, drop, pop;
  logic [REC_AW-1:0]    head, tail, rec_count;
  logic [WAVE_AW:0]     wave_used;
  out_state_t           st;
  logic                 bus_wr, cmd_hit, do_accept, do_reject, lm_load;
  logic [31:0]          rd_mux;
  logic [CNT_W-1:0]     cnt [N_CNT];
  logic [N_CNT-1:0]     cnt_en;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < BUS_BYTES; i++) begin
      if (be[i]) begin
        r[i*BYTE_W +: BYTE_W] = wd[i*BYTE_W +: BYTE_W];
      end
    end
    return r;
  endfunction

  // Pins are asynchronous to sys_clk
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  assign run      = ctrl_reg[CTRL_RUN];
  assign pur_en   = ctrl_reg[CTRL_PUR];
  assign range    = filt_reg[FILT_RANGE +: RANGE_W];
  assign len_sum  = {1'b0, filt_reg[FILT_RISE +: LEN_W]}
                  + {1'b0, filt_reg[FILT_FLAT +: LEN_W]};
  assign filt_len = (len_sum > {1'b0, FILT_LEN_MAX}) ? FILT_LEN_MAX
                  : len_sum[LEN_W-1:0];

  // Decimation: filter range n averages 2^n samples for n up to 6; range 7 sums 64 samples and shifts by 7
  assign dec_mask  = DEC_W'((1 << range) - 1);
  assign slot_mask = (range >= SLOT_RANGE)
                   ? DEC_W'((1 << (range - SLOT_RANGE)) - 1) : '0;
  assign dec_en    = (dec_cnt & dec_mask) == dec_mask;
  assign slot_ok   = (dec_cnt & slot_mask) == slot_mask;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_cnt          <= '0;
      avg_acc          <= '0;
      decimated_sample <= '0;
      timestamp        <= '0;
    end else begin
      dec_cnt   <= dec_cnt + 1'b1;
      timestamp <= timestamp + 1'b1;
      if (dec_en) begin
        decimated_sample <= ADC_W'((avg_acc + pin_s2.adc) >> range);
        avg_acc          <= '0;
      end else begin
        avg_acc <= avg_acc + pin_s2.adc;
      end
    end
  end

  // Acquisition gating
  assign rec_full  = rec_count == REC_AW'(REC_DEPTH);
  assign wave_full = (wave_used + trace_reg[WAVE_AW-1:0])
                   > (WAVE_AW+1)'(WAVE_DEPTH);
  assign paused    = rec_full || wave_full || lm_mem_full;
  assign oor_dead  = pin_s2.oor || (oor_cnt != '0);
  assign acq_ok    = run && !paused && !oor_dead;
  assign count_on  = acq_ok;

  // Out-of-range hold: several filter lengths to purge filter memory
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oor_cnt <= '0;
    end else if (pin_s2.oor) begin
      oor_cnt <= OOR_W'({filt_len, 2'b00}) << (OOR_HOLD_SHIFT - 2'd2);
    end else if (dec_en && oor_cnt != '0) begin
      oor_cnt <= oor_cnt - 1'b1;
    end
  end

  // Trigger: one per excursion above threshold
  assign over      = trig_filter > thr_reg[TRIG_W-1:0];
  assign trig_rise = over && !over_q && acq_ok;
  assign trig_dec  = dec_en && (trig_pend || trig_rise);
  assign tot_hit   = over && (maxw_reg[TRIG_W-1:0] != '0)
                   && (over_cnt == maxw_reg[TRIG_W-1:0]);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      over_q    <= 1'b0;
      over_cnt  <= '0;
      trig_pend <= 1'b0;
    end else begin
      over_q   <= over;
      over_cnt <= over ? over_cnt + 1'b1 : '0;
      if (dec_en) begin
        trig_pend <= 1'b0;
      end else if (trig_rise) begin
        trig_pend <= 1'b1;
      end
    end
  end

  // Edge bookkeeping; waveform start is pointer minus pre-trigger
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_edge_ts <= '0;
      last_addr    <= '0;
    end else if (trig_rise) begin
      last_edge_ts <= timestamp[EDGE_TS_W-1:0];
      last_addr    <= wr_ptr - pre_reg[WAVE_AW-1:0];
    end
  end

  // Strobe line: staged, so closely spaced edges each get a strobe
  assign strobe = dec_en && strobe_line[filt_len - 1'b1];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_line <= '0;
    end else if (dec_en) begin
      strobe_line <= {strobe_line[LINE_W-2:0], trig_pend || trig_rise};
    end
  end

  // Filter busy window T0..T1 and pileup status
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= '0;
      pile     <= 1'b0;
    end else begin
      if (trig_dec) begin
        busy_cnt <= filt_len;
        pile     <= busy_cnt != '0;
      end else if (dec_en && busy_cnt != '0) begin
        busy_cnt <= busy_cnt - 1'b1;
      end
      if (tot_hit) begin
        pile <= 1'b1;
      end
    end
  end

  // Capture at T1; pileup latched with the sums
  assign push = cap_pend && slot_ok && !rec_full
             && !(pur_en && cap_rec.pileup);
  assign drop = cap_pend && slot_ok && !push;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_rec  <= '0;
      cap_pend <= 1'b0;
    end else if (strobe) begin
      cap_rec.ts         <= timestamp;
      cap_rec.edge_ts    <= last_edge_ts;
      cap_rec.sums       <= energy_sums;
      cap_rec.pileup     <= pile;
      cap_rec.coinc      <= coinc_flags;
      cap_rec.start_addr <= last_addr;
      cap_rec.trace_len  <= trace_reg[WAVE_AW-1:0];
      cap_pend           <= 1'b1;
    end else if (push || drop) begin
      cap_pend <= 1'b0;
    end
  end

  // Waveform memory, written every sample as a ring
  always_ff @(posedge sys_clk) begin
    wave_mem[wr_ptr] <= pin_s2.adc;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // Record buffer
  always_ff @(posedge sys_clk) begin
    if (push) begin
      rec_mem[tail] <= cap_rec;
    end
  end

  assign head_rec = rec_mem[head];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      head              <= '0;
      tail              <= '0;
      rec_count         <= '0;
      wave_used         <= '0;
      records_available <= 1'b0;
    end else begin
      if (push) begin
        tail <= (tail == REC_AW'(REC_DEPTH - 1)) ? '0 : tail + 1'b1;
      end
      if (pop) begin
        head <= (head == REC_AW'(REC_DEPTH - 1)) ? '0 : head + 1'b1;
      end
      rec_count <= rec_count + REC_AW'(push) - REC_AW'(pop);
      wave_used <= wave_used
                 + (push ? {1'b0, cap_rec.trace_len} : '0)
                 - (pop ? {1'b0, head_rec.trace_len} : '0);
      records_available <= (rec_count + REC_AW'(push) - REC_AW'(pop))
                         != '0;
    end
  end

  // Processor command: accept streams, reject only pops
  assign bus_wr    = avs_write && !avs_waitrequest;
  assign cmd_hit   = bus_wr && avs_address == ADDR_CMD && st == ST_IDLE
                  && rec_count != '0;
  assign do_accept = cmd_hit && avs_writedata == CMD_ACCEPT;
  assign do_reject = cmd_hit && avs_writedata == CMD_REJECT;
  assign lm_load   = (!lm_out.valid || lm_ready)
                  && (st == ST_HDR || (st == ST_WAVE && left != '0));
  assign pop       = do_reject
                  || (st == ST_WAVE && left == '0 && lm_load == 1'b0
                      && (!lm_out.valid || lm_ready));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st     <= ST_IDLE;
      rd_ptr <= '0;
      left   <= '0;
    end else begin
      case (st)
        ST_IDLE: begin
          if (do_accept) begin
            st     <= ST_HDR;
            rd_ptr <= head_rec.start_addr;
            left   <= head_rec.trace_len;
          end
        end
        ST_HDR: begin
          if (lm_load) begin
            st <= ST_WAVE;
          end
        end
        ST_WAVE: begin
          if (lm_load) begin
            rd_ptr <= rd_ptr + 1'b1;
            left   <= left - 1'b1;
          end else if (pop) begin
            st <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lm_out <= '0;
    end else if (lm_load) begin
      lm_out.valid <= 1'b1;
      lm_out.data  <= (st == ST_HDR) ? hdr_reg
                    : 32'(wave_mem[rd_ptr]);
    end else if (lm_ready) begin
      lm_out.valid <= 1'b0;
    end
  end

  // Time counters; cleared when a run starts
  assign run_start        = run && !run_q;
  assign cnt_en[CNT_TOTAL] = run;
  assign cnt_en[CNT_RUN]   = run;
  assign cnt_en[CNT_COUNT] = count_on;
  assign cnt_en[CNT_SLOW_FILTER_DEAD_TIME]  = count_on
                                            && busy_cnt != '0;
  assign cnt_en[CNT_FAST_TRIGGER_DEAD_TIME] = count_on && over;
  assign cnt_en[CNT_GATE]  = count_on && pin_s2.gate;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run;
    end
  end

  for (genvar g = 0; g < N_CNT; g++) begin : g_cnt
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt[g] <= '0;
      end else if (run_start) begin
        cnt[g] <= '0;
      end else if (cnt_en[g]) begin
        cnt[g] <= cnt[g] + 1'b1;
      end
    end
  end

  // Avalon slave: one wait state per access
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_mux : '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg  <= '0;
      thr_reg   <= '0;
      maxw_reg  <= '0;
      pre_reg   <= '0;
      trace_reg <= '0;
      filt_reg  <= '0;
      hdr_reg   <= '0;
    end else if (bus_wr) begin
      case (avs_address)
        ADDR_CTRL: ctrl_reg <= merge(ctrl_reg, avs_writedata,
                                     avs_byteenable) & MASK_CTRL;
        ADDR_THRESH: thr_reg <= merge(thr_reg, avs_writedata,
                                      avs_byteenable) & MASK_16;
        ADDR_MAXW: maxw_reg <= merge(maxw_reg, avs_writedata,
                                     avs_byteenable) & MASK_16;
        ADDR_PRETRIG: pre_reg <= merge(pre_reg, avs_writedata,
                                       avs_byteenable) & MASK_13;
        ADDR_TRACE: trace_reg <= merge(trace_reg, avs_writedata,
                                       avs_byteenable) & MASK_13;
        ADDR_FILTER: filt_reg <= merge(filt_reg, avs_writedata,
                                       avs_byteenable) & MASK_FILTER;
        ADDR_HDR: hdr_reg <= merge(hdr_reg, avs_writedata, avs_byteenable);
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_mux = '0;
    case (avs_address)
      ADDR_CTRL:     rd_mux = ctrl_reg;
      ADDR_THRESH:   rd_mux = thr_reg;
      ADDR_MAXW:     rd_mux = maxw_reg;
      ADDR_PRETRIG:  rd_mux = pre_reg;
      ADDR_TRACE:    rd_mux = trace_reg;
      ADDR_FILTER:   rd_mux = filt_reg;
      ADDR_HDR:      rd_mux = hdr_reg;
      ADDR_STATUS:   rd_mux = 32'({st != ST_IDLE, oor_dead, paused,
                                   records_available, rec_count});
      ADDR_REC_TSL:  rd_mux = head_rec.ts[31:0];
      ADDR_REC_TSH:  rd_mux = 32'(head_rec.ts[TS_W-1:32]);
      ADDR_REC_EDGE: rd_mux = head_rec.edge_ts;
      ADDR_REC_SUM0: rd_mux = head_rec.sums[0];
      ADDR_REC_SUM1: rd_mux = head_rec.sums[1];
      ADDR_REC_SUM2: rd_mux = head_rec.sums[2];
      ADDR_REC_INFO: rd_mux = 32'({head_rec.coinc, head_rec.pileup,
                                   head_rec.trace_len, head_rec.start_addr});
      default: begin
        if (avs_address >= ADDR_CNT_BASE && avs_address <= ADDR_CNT_LAST)
        begin
          rd_mux = cnt[3'((avs_address - ADDR_CNT_BASE) >> 2)];
        end
      end
    endcase
  end

  sequence s_accept;
    do_accept ##1 (st == ST_HDR);
  endsequence

  sequence s_hdr_out;
    (st == ST_HDR && lm_load) ##1 lm_out.valid;
  endsequence

  avail_flag_a: assert property (
    (rec_count != '0) && !pop |=> records_available)
    else $error("records flag low with records held");
  rec_bound_a: assert property (rec_count <= REC_AW'(REC_DEPTH))
    else $error("record count above depth");
  push_count_a: assert property (
    push && !pop |=> rec_count == $past(rec_count) + 1'b1)
    else $error("push did not add a record");
  pile_drop_a: assert property (
    cap_pend && pur_en && cap_rec.pileup |-> !push)
    else $error("piled record entered buffer");
  pause_count_a: assert property (
    paused && !run_start |=> $stable(cnt[CNT_COUNT]))
    else $error("count time ran while paused");
  oor_trig_a: assert property (oor_dead |-> !trig_rise)
    else $error("trigger during out of range");
  dead_gate_a: assert property (
    !count_on && !run_start
    |=> $stable(cnt[CNT_SLOW_FILTER_DEAD_TIME])
        && $stable(cnt[CNT_FAST_TRIGGER_DEAD_TIME]))
    else $error("dead counter ran with count time off");
  run_time_a: assert property (
    run && run_q |=> cnt[CNT_RUN] == $past(cnt[CNT_RUN]) + 1'b1)
    else $error("run time did not advance");
  reject_quiet_a: assert property (
    do_reject |=> (st == ST_IDLE && !lm_out.valid) [*2])
    else $error("rejected record started output");
  accept_hdr_a: assert property (
    s_accept |-> s_hdr_out)
    else $error("header not sent after accept");
  hdr_word_a: assert property (
    (st == ST_HDR && lm_load) |=> lm_out.data == $past(hdr_reg))
    else $error("first beat is not the header");
  one_trig_a: assert property (over_q |-> !trig_rise)
    else $error("second trigger above threshold");
endmodule

// *** lm_sink.sv ***
module lm_sink (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire pulse_capture_pkg::lm_beat_t lm_out,
  input  wire logic                    stall,
  output logic                         lm_ready,
  output int                           beats,
  output logic [31:0]                  first_word,
  output int                           seq_errs
);
  timeunit 1ns;
  timeprecision 1ps;
  import pulse_capture_pkg::*;
  logic [13:0] last;
  logic        last_hdr;
  logic        ph;
  // Half-rate ready while stalling, so beats must hold until taken
  assign lm_ready = !stall || ph;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 1'b0;
      beats <= 0;
      first_word <= 32'h0;
      seq_errs <= 0;
      last <= 14'h0;
      last_hdr <= 1'b1;
    end else begin
      ph <= !ph;
      if (lm_out.valid && lm_ready) begin
        beats <= beats + 1;
        last <= lm_out.data[13:0];
        // Header words carry upper bits, samples never do
        last_hdr <= (lm_out.data[31:14] != 18'h0);
        if (lm_out.data[31:14] != 18'h0)
          first_word <= lm_out.data;
        else if (!last_hdr && lm_out.data[13:0] != last + 14'h1)
          seq_errs <= seq_errs + 1;
      end
    end
  end
endmodule

// *** pulse_event_capture_deadtime_bench.sv ***
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH %0t %s", $time, m); end end
module pulse_event_capture_deadtime_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pulse_capture_pkg::*;
  logic        sys_clk, rst_n, avs_read, avs_write, lm_ready, stall;
  logic        avs_waitrequest, records_available, lm_mem_full;
  pins_t       pin_in;
  logic [15:0] trig_filter;
  sums_t       energy_sums;
  logic [3:0]  coinc_flags;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, first_word, q, q2;
  logic [13:0] decimated_sample;
  lm_beat_t    lm_out;
  int          mismatches, n_tests, beats, seq_errs, b0, cyc;
  pulse_event_capture_deadtime dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .pin_in(pin_in), .trig_filter(trig_filter), .energy_sums(energy_sums),
    .coinc_flags(coinc_flags), .lm_ready(lm_ready),
    .lm_mem_full(lm_mem_full), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .records_available(records_available),
    .decimated_sample(decimated_sample), .lm_out(lm_out));
  lm_sink sink (.sys_clk(sys_clk), .rst_n(rst_n), .lm_out(lm_out),
    .stall(stall), .lm_ready(lm_ready), .beats(beats),
    .first_word(first_word), .seq_errs(seq_errs));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = !sys_clk;
  end
  // Ramp keeps every stored sample distinct
  always @(posedge sys_clk) pin_in.adc <= pin_in.adc + 14'h1;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    `CHK(n < 50, 1'b1, "bus hang")
  endtask
  task automatic pulse(input int w);
    @(posedge sys_clk);
    trig_filter <= 16'h0100;
    repeat (w) @(posedge sys_clk);
    trig_filter <= 16'h0000;
  endtask
  task automatic wait_avail();
    for (int i = 0; i < 100 && records_available !== 1'b1; i++)
      @(posedge sys_clk);
    `CHK(records_available, 1'b1, "no record")
  endtask
  task automatic t_accept();
    pulse(3);
    wait_avail();
    bus(0, ADDR_REC_INFO, 0, q);
    `CHK(q[25:13], 13'h4, "trace length")
    `CHK(q[26], 1'b0, "pileup flag")
    bus(0, ADDR_REC_EDGE, 0, q2);
    `CHK(q[12:0], q2[12:0] - 13'h2, "start address")
    bus(0, ADDR_REC_SUM0, 0, q);
    `CHK(q, 32'h0000_1234, "sum")
    bus(1, ADDR_HDR, 32'hABCD_0000, q);
    b0 = beats;
    bus(1, ADDR_CMD, CMD_ACCEPT, q);
    for (int i = 0; i < 100 && beats != b0 + 5; i++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    `CHK(beats - b0, 5, "beat count")
    `CHK(first_word, 32'hABCD_0000, "header")
    `CHK(seq_errs, 0, "sample order")
    `CHK(records_available, 1'b0, "not popped")
  endtask
  task automatic t_reject();
    pulse(3);
    wait_avail();
    b0 = beats;
    bus(1, ADDR_CMD, CMD_REJECT, q);
    repeat (20) @(posedge sys_clk);
    `CHK(beats, b0, "rejected streamed")
    `CHK(records_available, 1'b0, "rejected kept")
  endtask
  task automatic t_pileup();
    pulse(1);
    pulse(1);
    repeat (60) @(posedge sys_clk);
    `CHK(records_available, 1'b0, "pileup kept")
    bus(1, ADDR_MAXW, 32'h0000_0002, q);
    pulse(6);
    repeat (20) @(posedge sys_clk);
    `CHK(records_available, 1'b0, "wide pulse kept")
    bus(1, ADDR_MAXW, 32'h0000_0000, q);
  endtask
  // Gate counter frozen while list memory full, runs once it drains
  task automatic t_hold();
    pin_in.gate <= 1'b1;
    lm_mem_full <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK(decimated_sample, pin_in.adc - 14'h3, "decimated sample")
    bus(0, ADDR_CNT_LAST, 0, q);
    repeat (10) @(posedge sys_clk);
    bus(0, ADDR_CNT_LAST, 0, q2);
    `CHK(q2, q, "gate ran while paused")
    lm_mem_full <= 1'b0;
    repeat (4) @(posedge sys_clk);
    bus(0, ADDR_CNT_LAST, 0, q2);
    `CHK(q2 > q, 1'b1, "gate stopped")
    pin_in.gate <= 1'b0;
  endtask
  task automatic t_oor();
    bus(0, ADDR_CNT_BASE, 0, q2);
    pin_in.oor <= 1'b1;
    repeat (4) @(posedge sys_clk);
    bus(0, ADDR_CNT_BASE + 8'h08, 0, q);
    repeat (20) @(posedge sys_clk);
    bus(0, ADDR_CNT_BASE + 8'h08, 0, b0);
    `CHK(q, b0, "count ran")
    bus(0, ADDR_CNT_BASE, 0, q);
    `CHK(q > q2, 1'b1, "total stopped")
    pin_in.oor <= 1'b0;
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    {rst_n, avs_read, avs_write, lm_mem_full, stall} = 5'h0;
    {trig_filter, coinc_flags, avs_address, avs_writedata} = '0;
    pin_in = '0;
    energy_sums = {3{32'h0000_1234}};
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    stall <= 1'b1;
    bus(0, 8'hFC, 0, q);
    `CHK(q, 32'h0, "unmapped read")
    bus(1, ADDR_THRESH, 32'h0000_0080, q);
    bus(1, ADDR_TRACE, 32'h0000_0004, q);
    bus(1, ADDR_PRETRIG, 32'h0000_0002, q);
    bus(1, ADDR_FILTER, 32'h0000_0102, q);
    bus(1, ADDR_CTRL, 32'h0000_0003, q);
    t_accept();
    t_reject();
    t_pileup();
    t_hold();
    t_oor();
    give_verdict();
  end
endmodule
